// ### verilog/nbf_pkg.sv
// Constants shared by the NAND bad-block host controller.
// Assumes an 8-bit NAND part with 5 address cycles and one 20 MHz clock.
package nbf_pkg;
    localparam int PAGE_W      = 6;
    localparam int COL_W       = 13;
    localparam int ADDR_CYCLES = 5;
    localparam int ROW_FIRST   = 2;

    localparam logic [7:0] CMD_READ1  = 8'h00;
    localparam logic [7:0] CMD_READ2  = 8'h30;
    localparam logic [7:0] CMD_PROG1  = 8'h80;
    localparam logic [7:0] CMD_PROG2  = 8'h10;
    localparam logic [7:0] CMD_ERASE1 = 8'h60;
    localparam logic [7:0] CMD_ERASE2 = 8'hD0;
    localparam logic [7:0] CMD_STATUS = 8'h70;

    localparam logic [7:0] BAD_MARK = 8'h00;
    localparam logic [7:0] PAD_BYTE = 8'hFF;

    localparam int ST_FAIL_BIT    = 0;
    localparam int ST_REWRITE_BIT = 3;

    localparam logic [COL_W-1:0] BB_COL_DEF = 13'h0000;

    localparam int CLK_PERIOD_NS = 50;
    localparam int T_WB_NS       = 100;
    localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        OP_SCAN  = 4'h1,
        OP_READ  = 4'h2,
        OP_PROG  = 4'h4,
        OP_ERASE = 4'h8
    } nbf_op_e;
endpackage : nbf_pkg

// ### verilog/nbf_bbt.sv
// Bad-block table: one flag per block, cleared at scan start.
// Assumes mark and lookup block numbers are below NUM_BLOCKS.
`timescale 1ns/100ps
`default_nettype none
module nbf_bbt #(
    parameter int NUM_BLOCKS = 2048,
    parameter int BLK_W      = 11
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_clear,
    input  wire logic             i_mark,
    input  wire logic [BLK_W-1:0] i_mark_blk,
    input  wire logic [BLK_W-1:0] i_look_blk,
    output logic                  o_look_bad,
    output logic [BLK_W:0]        o_bad_cnt
);
    logic [NUM_BLOCKS-1:0] bad_q;
    logic [BLK_W:0]        cnt_q;

    genvar g;
    generate
        for (g = 0; g < NUM_BLOCKS; g++) begin : g_flag
            always_ff @(posedge i_ref_clk) begin
                if (i_sys_rst || i_clear) begin
                    bad_q[g] <= 1'b0;
                end else if (i_mark && i_mark_blk == BLK_W'(g)) begin
                    bad_q[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // Count only fresh marks so a repeat failure is not counted twice
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || i_clear) begin
            cnt_q <= '0;
        end else if (i_mark && !bad_q[i_mark_blk]) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign o_look_bad = bad_q[i_look_blk];
    assign o_bad_cnt  = cnt_q;
endmodule : nbf_bbt
`default_nettype wire

// ### verilog/nbf_host.sv
// NAND host controller: bad-block scan, program/erase/read with failure
// handling. Assumes NAND pins are synchronous to i_ref_clk and that the
// user holds write data until o_wr_ready and can replay its page buffer.
// What this block does
// - The scan reads one byte of one page per block and marks the block bad when it is 00h.
// - The scan decision uses only the byte read, never the status result.
// - An erase is never issued to a block that the table holds as bad.
// - Every erase is followed by a status read and a failing block is entered in the table.
// - Every program is followed by a status read and a failure replays the page into another block and marks the old one.
// - Every read is followed by a status read whose rewrite and fail bits are reported to the user.
// - Read errors never mark a block bad; only scan marks and program or erase failures do.
// - Replacement blocks come from a rotating pointer so relocations spread over all blocks.
// - Page space beyond the user data is padded with ones, not zeros.
// - While the memory is busy the controller issues no command, only watching ready/busy.
`timescale 1ns/100ps
`default_nettype none
module nbf_host #(
    parameter int                       NUM_BLOCKS = 2048,
    parameter int                       BLK_W      = 11,
    parameter int                       PAGE_BYTES = 4224,
    parameter logic [nbf_pkg::COL_W-1:0] BB_COL    = nbf_pkg::BB_COL_DEF
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_cmd_valid,
    input  wire nbf_pkg::nbf_op_e           i_cmd_op,
    input  wire logic [BLK_W-1:0]           i_cmd_blk,
    input  wire logic [nbf_pkg::PAGE_W-1:0] i_cmd_page,
    input  wire logic [nbf_pkg::COL_W-1:0]  i_cmd_len,
    output logic                            o_cmd_ready,
    output logic                            o_done,
    output logic                            o_fail,
    output logic                            o_rewrite,
    output logic                            o_uncorr,
    output logic [BLK_W-1:0]                o_result_blk,
    output logic [BLK_W:0]                  o_bad_cnt,
    input  wire logic [7:0]                 i_wr_data,
    input  wire logic                       i_wr_valid,
    output logic                            o_wr_ready,
    output logic                            o_wr_restart,
    output logic [7:0]                      o_rd_data,
    output logic                            o_rd_valid,
    output logic                            o_ce_n,
    output logic                            o_cle,
    output logic                            o_ale,
    output logic                            o_we_n,
    output logic                            o_re_n,
    output logic                            o_wp_n,
    input  wire logic [7:0]                 i_io,
    output logic [7:0]                      o_io,
    output logic                            o_io_oe,
    input  wire logic                       i_rb_n
);
    typedef enum logic [9:0] {
        S_IDLE  = 10'h001,
        S_CMD1  = 10'h002,
        S_ADDR  = 10'h004,
        S_CMD2  = 10'h008,
        S_WAIT  = 10'h010,
        S_RDATA = 10'h020,
        S_WDATA = 10'h040,
        S_STAT  = 10'h080,
        S_NEXT  = 10'h100,
        S_ALLOC = 10'h200
    } nbf_state_e;

    localparam int CW = nbf_pkg::COL_W;

    nbf_state_e                  state_q;
    nbf_pkg::nbf_op_e            op_q;
    logic                        phase_q;
    logic [CW-1:0]               idx_q;
    logic [CW-1:0]               len_q;
    logic [BLK_W-1:0]            blk_q;
    logic [BLK_W-1:0]            ptr_q;
    logic [BLK_W:0]              tries_q;
    logic [nbf_pkg::PAGE_W-1:0]  page_q;
    logic [7:0]                  stat_q;
    logic [7:0]                  rd_q;
    logic [1:0]                  wait_q;
    logic                        done_q;
    logic                        fail_q;
    logic                        rewrite_q;
    logic                        uncorr_q;
    logic                        rd_valid_q;
    logic                        restart_q;

    logic             is_scan, is_read, is_prog, is_erase;
    logic             look_bad, mark, clear, stat_cmd, stat_rd;
    logic             write_cyc, read_cyc, user_byte, last_cyc;
    logic             accept, blk_bad_st, stat_fail;
    logic [BLK_W-1:0] look_blk;
    logic [CW-1:0]    rd_len;
    logic [15:0]      col16;
    logic [23:0]      row24;
    logic [7:0]       bus_byte;

    assign is_scan  = (op_q == nbf_pkg::OP_SCAN);
    assign is_read  = (op_q == nbf_pkg::OP_READ);
    assign is_prog  = (op_q == nbf_pkg::OP_PROG);
    assign is_erase = (op_q == nbf_pkg::OP_ERASE);
    assign stat_cmd = (state_q == S_STAT) && (idx_q == '0);
    assign stat_rd  = (state_q == S_STAT) && (idx_q != '0);
    assign accept   = (state_q == S_IDLE) && i_cmd_valid;
    assign rd_len   = is_scan ? CW'(1) : len_q;
    assign stat_fail = stat_q[nbf_pkg::ST_FAIL_BIT];

    // Scan marks from the data byte alone; program/erase from status
    assign mark = (state_q == S_NEXT) &&
                  ((is_scan && rd_q == nbf_pkg::BAD_MARK) ||
                   ((is_prog || is_erase) && stat_fail));
    assign clear    = accept && (i_cmd_op == nbf_pkg::OP_SCAN);
    assign look_blk = (state_q == S_ALLOC) ? ptr_q : i_cmd_blk;
    assign blk_bad_st = accept && look_bad &&
                        (i_cmd_op != nbf_pkg::OP_SCAN);

    nbf_bbt #(
        .NUM_BLOCKS (NUM_BLOCKS),
        .BLK_W      (BLK_W)
    ) u_bbt (
        .i_ref_clk  (i_ref_clk),
        .i_sys_rst  (i_sys_rst),
        .i_clear    (clear),
        .i_mark     (mark),
        .i_mark_blk (blk_q),
        .i_look_blk (look_blk),
        .o_look_bad (look_bad),
        .o_bad_cnt  (o_bad_cnt)
    );

    assign col16 = {{(16-CW){1'b0}}, (is_scan ? BB_COL : CW'(0))};
    assign row24 = {{(24-BLK_W-nbf_pkg::PAGE_W){1'b0}}, blk_q, page_q};
    assign user_byte = idx_q < len_q;

    always_comb begin
        bus_byte = 8'h00;
        case (state_q)
            S_CMD1: begin
                bus_byte = is_prog  ? nbf_pkg::CMD_PROG1 :
                           is_erase ? nbf_pkg::CMD_ERASE1 : nbf_pkg::CMD_READ1;
            end
            S_CMD2: begin
                bus_byte = is_prog  ? nbf_pkg::CMD_PROG2 :
                           is_erase ? nbf_pkg::CMD_ERASE2 : nbf_pkg::CMD_READ2;
            end
            S_ADDR: begin
                case (idx_q[2:0])
                    3'h0:    bus_byte = col16[7:0];
                    3'h1:    bus_byte = col16[15:8];
                    3'h2:    bus_byte = row24[7:0];
                    3'h3:    bus_byte = row24[15:8];
                    default: bus_byte = row24[23:16];
                endcase
            end
            S_WDATA: begin
                bus_byte = user_byte ? i_wr_data : nbf_pkg::PAD_BYTE;
            end
            S_STAT: begin
                bus_byte = nbf_pkg::CMD_STATUS;
            end
            default: begin
                bus_byte = 8'h00;
            end
        endcase
    end

    assign write_cyc = (state_q == S_CMD1) || (state_q == S_ADDR) ||
                       (state_q == S_CMD2) || (state_q == S_WDATA) || stat_cmd;
    assign read_cyc  = (state_q == S_RDATA) || stat_rd;

    // Strobes low in phase 0, high in phase 1 latches the byte
    assign o_ce_n  = (state_q == S_IDLE);
    assign o_cle   = (state_q == S_CMD1) || (state_q == S_CMD2) || stat_cmd;
    assign o_ale   = (state_q == S_ADDR);
    assign o_we_n  = !(write_cyc && !phase_q);
    assign o_re_n  = !(read_cyc && !phase_q);
    assign o_io    = bus_byte;
    assign o_io_oe = write_cyc;
    // Write protect released only for program and erase
    assign o_wp_n  = (state_q != S_IDLE) && (is_prog || is_erase);
    assign o_cmd_ready = (state_q == S_IDLE);
    assign o_wr_ready  = (state_q == S_WDATA) && phase_q && user_byte;
    assign last_cyc    = phase_q;

    // Bus cycle phase; a user byte stalls phase 0 until valid
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            phase_q <= 1'b0;
        end else if (write_cyc || read_cyc) begin
            if ((state_q == S_WDATA) && !phase_q && user_byte && !i_wr_valid) begin
                phase_q <= 1'b0;
            end else begin
                phase_q <= !phase_q;
            end
        end else begin
            phase_q <= 1'b0;
        end
    end

    // Read bytes captured while RE is still low
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rd_q       <= 8'h00;
            stat_q     <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= 1'b0;
            if ((state_q == S_RDATA) && !phase_q) begin
                rd_q       <= i_io;
                rd_valid_q <= is_read;
            end
            if (stat_rd && !phase_q) begin
                stat_q <= i_io;
            end
        end
    end

    // Main sequencer
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_q   <= S_IDLE;
            op_q      <= nbf_pkg::OP_SCAN;
            idx_q     <= '0;
            len_q     <= '0;
            blk_q     <= '0;
            page_q    <= '0;
            ptr_q     <= '0;
            tries_q   <= '0;
            wait_q    <= '0;
            done_q    <= 1'b0;
            fail_q    <= 1'b0;
            rewrite_q <= 1'b0;
            uncorr_q  <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            done_q    <= 1'b0;
            restart_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (accept) begin
                        op_q      <= i_cmd_op;
                        blk_q     <= (i_cmd_op == nbf_pkg::OP_SCAN) ? '0 : i_cmd_blk;
                        page_q    <= (i_cmd_op == nbf_pkg::OP_SCAN) ? '0 : i_cmd_page;
                        len_q     <= i_cmd_len;
                        fail_q    <= blk_bad_st;
                        rewrite_q <= 1'b0;
                        uncorr_q  <= 1'b0;
                        if (blk_bad_st) begin
                            done_q <= 1'b1;
                        end else begin
                            state_q <= S_CMD1;
                        end
                    end
                end
                S_CMD1: begin
                    if (last_cyc) begin
                        state_q <= S_ADDR;
                        idx_q   <= is_erase ? CW'(nbf_pkg::ROW_FIRST) : '0;
                    end
                end
                S_ADDR: begin
                    if (last_cyc) begin
                        if (idx_q == CW'(nbf_pkg::ADDR_CYCLES - 1)) begin
                            idx_q   <= '0;
                            state_q <= is_prog ? S_WDATA : S_CMD2;
                        end else begin
                            idx_q <= idx_q + 1'b1;
                        end
                    end
                end
                S_WDATA: begin
                    if (last_cyc) begin
                        if (idx_q == CW'(PAGE_BYTES - 1)) begin
                            idx_q   <= '0;
                            state_q <= S_CMD2;
                        end else begin
                            idx_q <= idx_q + 1'b1;
                        end
                    end
                end
                S_CMD2: begin
                    if (last_cyc) begin
                        state_q <= S_WAIT;
                        wait_q  <= '0;
                    end
                end
                S_WAIT: begin
                    // No command goes out until ready returns
                    if (wait_q != 2'(nbf_pkg::WB_CYC)) begin
                        wait_q <= wait_q + 1'b1;
                    end else if (i_rb_n) begin
                        idx_q   <= '0;
                        state_q <= (is_scan || is_read) ? S_RDATA : S_STAT;
                    end
                end
                S_RDATA: begin
                    if (last_cyc) begin
                        if (idx_q == rd_len - 1'b1) begin
                            idx_q   <= '0;
                            state_q <= is_scan ? S_NEXT : S_STAT;
                        end else begin
                            idx_q <= idx_q + 1'b1;
                        end
                    end
                end
                S_STAT: begin
                    if (last_cyc) begin
                        if (stat_rd) begin
                            idx_q   <= '0;
                            state_q <= S_NEXT;
                        end else begin
                            idx_q <= CW'(1);
                        end
                    end
                end
                S_NEXT: begin
                    if (is_scan) begin
                        if (blk_q == BLK_W'(NUM_BLOCKS - 1)) begin
                            state_q <= S_IDLE;
                            done_q  <= 1'b1;
                        end else begin
                            blk_q   <= blk_q + 1'b1;
                            state_q <= S_CMD1;
                        end
                    end else if (is_prog && stat_fail) begin
                        tries_q <= '0;
                        state_q <= S_ALLOC;
                    end else begin
                        // Read results are only reported, never marked
                        rewrite_q <= is_read && stat_q[nbf_pkg::ST_REWRITE_BIT];
                        uncorr_q  <= is_read && stat_fail;
                        fail_q    <= is_erase && stat_fail;
                        done_q    <= 1'b1;
                        state_q   <= S_IDLE;
                    end
                end
                S_ALLOC: begin
                    // Rotating pointer spreads relocations over the array
                    ptr_q <= ptr_q + 1'b1;
                    if (!look_bad && ptr_q != blk_q) begin
                        blk_q     <= ptr_q;
                        restart_q <= 1'b1;
                        state_q   <= S_CMD1;
                    end else if (tries_q == (BLK_W+1)'(NUM_BLOCKS - 1)) begin
                        fail_q  <= 1'b1;
                        done_q  <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        tries_q <= tries_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    assign o_done       = done_q;
    assign o_fail       = fail_q;
    assign o_rewrite    = rewrite_q;
    assign o_uncorr     = uncorr_q;
    assign o_result_blk = blk_q;
    assign o_rd_data    = rd_q;
    assign o_rd_valid   = rd_valid_q;
    assign o_wr_restart = restart_q;
endmodule : nbf_host
`default_nettype wire

// ### bench/nbf_host_properties.sv
// Pin and handshake checks for the NAND host controller.
// Bound into every nbf_host; sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module nbf_chk #(
    parameter int BLK_W = 11
) (
    input wire logic             i_ref_clk,
    input wire logic             i_sys_rst,
    input wire logic             i_cmd_valid,
    input wire nbf_pkg::nbf_op_e i_cmd_op,
    input wire logic             o_cmd_ready,
    input wire logic             o_done,
    input wire logic             o_fail,
    input wire logic [BLK_W:0]   o_bad_cnt,
    input wire logic             o_cle,
    input wire logic             o_we_n,
    input wire logic             o_re_n,
    input wire logic [7:0]       o_io,
    input wire logic             i_rb_n
);
    logic tk, tk_s, tk_e, tk_o, wc, rd_q, sc_q;
    assign tk = i_cmd_valid && o_cmd_ready;
    assign tk_s = tk && i_cmd_op == nbf_pkg::OP_SCAN;
    assign tk_e = tk && i_cmd_op == nbf_pkg::OP_ERASE;
    assign tk_o = tk && !tk_s && !tk_e;
    assign wc = o_cle && !o_we_n;
    // Open operation kind, so table changes can be tied to it
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || o_done) begin
            rd_q <= 1'b0;
            sc_q <= 1'b0;
        end else if (tk) begin
            rd_q <= i_cmd_op == nbf_pkg::OP_READ;
            sc_q <= tk_s;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // CLE may still stand in the cycle after the closing write strobe
    property p_busy; !i_rb_n |-> o_we_n && o_re_n; endproperty
    a_busy: assert property (p_busy) else $error("strobe while busy");
    property p_rd; rd_q |-> $stable(o_bad_cnt); endproperty
    a_rd: assert property (p_rd) else $error("read changed table");
    property p_grow; !sc_q && !tk_s |=> o_bad_cnt >= $past(o_bad_cnt); endproperty
    a_grow: assert property (p_grow) else $error("table shrank");
    property p_scan; tk_s |=> wc && o_io == nbf_pkg::CMD_READ1; endproperty
    a_scan: assert property (p_scan) else $error("scan start");
    property p_er;
        tk_e |=> (wc && o_io == nbf_pkg::CMD_ERASE1) || (o_done && o_fail);
    endproperty
    a_er: assert property (p_er) else $error("erase start");
    property p_ref; tk_o |=> wc || (o_done && o_fail); endproperty
    a_ref: assert property (p_ref) else $error("op start");
    property p_est;
        wc && o_io == nbf_pkg::CMD_ERASE2 |->
            ##[2:400] wc && o_io == nbf_pkg::CMD_STATUS;
    endproperty
    a_est: assert property (p_est) else $error("no erase status");
    property p_pst;
        wc && o_io == nbf_pkg::CMD_PROG2 |->
            ##[2:400] wc && o_io == nbf_pkg::CMD_STATUS;
    endproperty
    a_pst: assert property (p_pst) else $error("no prog status");
endmodule : nbf_chk
bind nbf_host nbf_chk #(.BLK_W(BLK_W)) chk_u (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
    .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_fail(o_fail),
    .o_bad_cnt(o_bad_cnt), .o_cle(o_cle), .o_we_n(o_we_n),
    .o_re_n(o_re_n), .o_io(o_io), .i_rb_n(i_rb_n));
`default_nettype wire

// ### bench/nbf_nand.sv
// Behavioural NAND part: factory marks, failing blocks, busy time.
// Assumes strobes change after the rising edge and are sampled on it.
`timescale 1ns/100ps
`default_nettype none
module nbf_nand #(
    parameter int BW = 3
) (
    input  wire logic       i_clk,
    input  wire logic       i_ce_n,
    input  wire logic       i_cle,
    input  wire logic       i_ale,
    input  wire logic       i_we_n,
    input  wire logic       i_re_n,
    input  wire logic [7:0] i_io,
    output logic      [7:0] o_io,
    output logic            o_rb_n
);
    logic [7:0] cmd, col, st, pg [16], mk [2**BW];
    logic [7:0] last = 8'h00;
    logic [23:0] row;
    logic [BW-1:0] b;
    int na, busy = 0, viol = 0, bad_er = 0, n_er = 0, n_pr = 0;
    assign b = row[6 +: BW];
    assign o_rb_n = busy == 0;
    // Released bus shows the inverse of the last byte, never a stale copy
    assign o_io = i_re_n ? ~last : cmd == nbf_pkg::CMD_STATUS ? st
                : col == 8'h00 ? mk[b] : 8'hA5 ^ col;
    // Block 4 is nearly a mark but must stay good
    initial foreach (mk[i]) mk[i] = (i == 2 || i == 5) ? 8'h00 :
                                    (i == 4) ? 8'h01 : 8'hFF;
    always @(posedge i_clk) begin
        if (busy > 0) busy <= busy - 1;
        if (!i_ce_n && !i_re_n) begin
            last <= o_io;
            if (cmd != nbf_pkg::CMD_STATUS) col <= col + 8'h01;
        end
        if (!i_ce_n && !i_we_n && i_cle) begin
            cmd <= i_io;
            na <= 0;
            if (!o_rb_n && i_io != nbf_pkg::CMD_STATUS) viol <= viol + 1;
            if (i_io == nbf_pkg::CMD_ERASE2) n_er <= n_er + 1;
            if (i_io == nbf_pkg::CMD_ERASE2 && mk[b] == 8'h00) bad_er++;
            if (i_io == nbf_pkg::CMD_PROG2) n_pr <= n_pr + 1;
            if (i_io inside {nbf_pkg::CMD_READ2, nbf_pkg::CMD_PROG2,
                             nbf_pkg::CMD_ERASE2}) begin
                busy <= i_io == nbf_pkg::CMD_ERASE2 ? 40 : 5;
                // Block 7 holds 9+ bit errors, block 0 is near the limit
                st <= {4'hE, b == 0 && i_io == nbf_pkg::CMD_READ2, 2'h0,
                       i_io == nbf_pkg::CMD_ERASE2 ? b == 6 :
                       i_io == nbf_pkg::CMD_PROG2 ? b == 1 : b == 7};
            end
        end else if (!i_ce_n && !i_we_n && i_ale) begin
            if (cmd == nbf_pkg::CMD_ERASE1) row[8*na +: 8] <= i_io;
            else if (na > 1) row[8*(na-2) +: 8] <= i_io;
            else if (na == 0) col <= i_io;
            na <= na + 1;
        end else if (!i_ce_n && !i_we_n && cmd == nbf_pkg::CMD_PROG1) begin
            pg[col] <= i_io;
            col <= col + 8'h01;
        end
    end
endmodule : nbf_nand
`default_nettype wire

// ### bench/test_nbf_host.sv
// Bench for the NAND host controller against a behavioural part.
// Small part of 8 blocks with 8-byte pages; one 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module test_nbf_host;
    logic clk, rst, cv, wv, rdy, dn, fl, rw, uc, wrdy, wrs, rv;
    logic ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n;
    logic [7:0] wd, rd, io_o, io_i;
    logic [7:0] wb [16] = '{0: 8'h12, 1: 8'h34, 2: 8'h56, default: 8'h00};
    logic [2:0] blk, rblk;
    logic [3:0] bc;
    logic [12:0] len;
    nbf_pkg::nbf_op_e op;
    logic [7:0] rq [$];
    int fails = 0, n_tests = 0, wi = 0, cyc = 0, n0;
    nbf_host #(.NUM_BLOCKS(8), .BLK_W(3), .PAGE_BYTES(8)) dut_u (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_cmd_valid(cv), .i_cmd_op(op),
        .i_cmd_blk(blk), .i_cmd_page(6'h00), .i_cmd_len(len),
        .o_cmd_ready(rdy), .o_done(dn), .o_fail(fl), .o_rewrite(rw),
        .o_uncorr(uc), .o_result_blk(rblk), .o_bad_cnt(bc),
        .i_wr_data(wd), .i_wr_valid(wv), .o_wr_ready(wrdy),
        .o_wr_restart(wrs), .o_rd_data(rd), .o_rd_valid(rv),
        .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n),
        .o_re_n(re_n), .o_wp_n(wp_n), .i_io(io_i), .o_io(io_o),
        .o_io_oe(oe), .i_rb_n(rb_n));
    nbf_nand #(.BW(3)) m_u (
        .i_clk(clk), .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale),
        .i_we_n(we_n), .i_re_n(re_n), .i_io(io_o), .o_io(io_i),
        .o_rb_n(rb_n));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Page buffer replays from byte 0 on restart
    always @(negedge clk) begin
        wd <= wb[wi];
        wv <= op == nbf_pkg::OP_PROG && wi < len;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cv || wrs) wi <= 0;
        else if (wrdy && wv) wi <= wi + 1;
        if (rv) rq.push_back(rd);
        if (cyc == 20000) begin
            fails++;
            complete_run;
        end
    end
    task automatic complete_run;
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic run(input nbf_pkg::nbf_op_e o, input int b, input int n);
        int k;
        @(negedge clk);
        op = o;
        blk = 3'(b);
        len = 13'(n);
        cv = 1'b1;
        rq.delete();
        @(negedge clk);
        cv = 1'b0;
        k = 0;
        while (dn !== 1'b1 && k < 5000) begin
            @(posedge clk);
            #1;
            k++;
        end
        @(negedge clk);
    endtask : run
    task automatic t_scan;
        run(nbf_pkg::OP_SCAN, 0, 1);
        chk(bc, 2);
        chk(rblk, 7);
    endtask : t_scan
    task automatic t_refuse;
        n0 = m_u.n_er;
        run(nbf_pkg::OP_ERASE, 2, 0);
        chk({fl, 15'(m_u.n_er - n0)}, 16'h8000);
        run(nbf_pkg::OP_READ, 5, 1);
        chk({fl, 15'(rq.size())}, 16'h8000);
    endtask : t_refuse
    task automatic t_erase;
        run(nbf_pkg::OP_ERASE, 3, 0);
        chk(fl, 0);
        run(nbf_pkg::OP_ERASE, 6, 0);
        chk({fl, bc}, {1'b1, 4'h3});
        n0 = m_u.n_er;
        run(nbf_pkg::OP_ERASE, 6, 0);
        chk({fl, 15'(m_u.n_er - n0)}, 16'h8000);
    endtask : t_erase
    task automatic t_prog;
        n0 = m_u.n_pr;
        run(nbf_pkg::OP_PROG, 1, 3);
        chk({fl, bc}, {1'b0, 4'h4});
        chk(16'(m_u.n_pr - n0), 2);
        chk(16'(rblk inside {1, 2, 5, 6}), 0);
        for (int i = 0; i < 8; i++) chk(m_u.pg[i], i < 3 ? wb[i] : 8'hFF);
        run(nbf_pkg::OP_PROG, 1, 3);
        chk(fl, 1);
    endtask : t_prog
    task automatic t_read;
        run(nbf_pkg::OP_READ, 0, 2);
        chk(16'(rq.size()), 2);
        chk({rq[0], rq[1]}, 16'hFFA4);
        chk({rw, uc, fl}, 3'h4);
        run(nbf_pkg::OP_READ, 7, 1);
        chk({rw, uc, fl, bc}, {3'h2, 4'h4});
    endtask : t_read
    initial begin
        rst = 1'b1;
        cv = 1'b0;
        op = nbf_pkg::OP_SCAN;
        blk = 3'h0;
        len = 13'h0000;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chk(bc, 0);
        chk({ce_n, we_n, re_n, cle, ale, wp_n, oe}, 7'h70);
        t_scan;
        t_refuse;
        t_erase;
        t_prog;
        t_read;
        chk(16'(m_u.viol), 0);
        chk(16'(m_u.bad_er), 0);
        complete_run;
    end
endmodule : test_nbf_host
`default_nettype wire
